// *** dsw_top.sv ***
/*
 * dsw_top: builds the four cyclic input words a motor drive publishes
 * to the network master, and answers word reads at node addresses.
 * Assumes drive state and settings are synchronous to ref_clk and that
 * node_number is 1 or more while reads are made.
 */
`timescale 1ns/10ps
module dsw_top
   import dsw_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = DSW_TICK_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire dsw_settings_t settings,
   input wire dsw_state_t state,
   input wire logic [7:0] node_number,
   input wire logic rd_strobe,
   input wire logic [15:0] rd_addr,
   output logic [15:0] rd_data,
   output logic rd_valid,
   output logic rd_miss,
   output logic [15:0] drive_status_word,
   output logic [15:0] fault_and_life_word,
   output logic [15:0] output_frequency_word,
   output logic [15:0] output_current_word
);
   // node base in word addresses
   function automatic logic [15:0] node_base(input logic [7:0] node);
      logic [15:0] idx;
      idx = {8'h00, node} - {8'h00, DSW_NODE_FIRST};
      return {idx[13:0], 2'b00};
   endfunction

   // ceil test: a >= b with unsigned 16-bit operands
   function automatic logic at_or_above(input logic [15:0] a,
                                        input logic [15:0] b);
      return a >= b;
   endfunction

   logic [13:0] tick_count_reg;
   logic tick_reg;
   logic ready_reg;
   logic cur_above;
   logic cur_below;
   logic cur_detect;
   logic zero_detect;
   logic [15:0] freq_diff;
   logic [15:0] detect_threshold;
   logic [15:0] status_next;
   logic [15:0] fault_next;
   logic [15:0] rd_offset;
   logic [15:0] base;

   // millisecond tick for the detection timers
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_count_reg <= 14'h0000;
         tick_reg <= 1'b0;
      end else if (tick_count_reg == 14'(TICK_CYCLES - 1)) begin
         tick_count_reg <= 14'h0000;
         tick_reg <= 1'b1;
      end else begin
         tick_count_reg <= tick_count_reg + 14'h0001;
         tick_reg <= 1'b0;
      end
   end

   // ready only after reset release and drive startup finished
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= state.startup_done;
      end
   end

   assign cur_above = state.output_current > settings.current_detect_level;
   assign cur_below = state.output_current < settings.zero_current_level;

   dsw_persist u_cur_detect (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick_reg),
      .cond(cur_above),
      .limit(settings.current_detect_time),
      .flag(cur_detect)
   );

   dsw_persist u_zero_detect (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick_reg),
      .cond(cur_below),
      .limit(settings.zero_current_time),
      .flag(zero_detect)
   );

   // both operands in 0.01 Hz; no display-unit scaling applies here
   always_comb begin
      if (state.output_frequency >= state.set_frequency) begin
         freq_diff = state.output_frequency - state.set_frequency;
      end else begin
         freq_diff = state.set_frequency - state.output_frequency;
      end
   end

   always_comb begin
      if (state.direction_reverse) begin
         detect_threshold = settings.reverse_detect_threshold;
      end else begin
         detect_threshold = settings.forward_detect_threshold;
      end
   end

   // unused bits stay zero by starting from all-clear
   always_comb begin
      status_next = 16'h0000;
      status_next[DSW_BIT_FWD] = state.output_active &&
                                 !state.direction_reverse;
      status_next[DSW_BIT_REV] = state.output_active &&
                                 state.direction_reverse;
      status_next[DSW_BIT_RUN] = at_or_above(state.output_frequency,
         settings.starting_frequency_setting);
      status_next[DSW_BIT_UP_TO_FREQ] = state.output_active &&
         (freq_diff <= settings.frequency_reach_band_setting);
      status_next[DSW_BIT_OVERLOAD] = state.stall_active;
      status_next[DSW_BIT_FREQ_DETECT] = state.output_active &&
         at_or_above(state.output_frequency, detect_threshold);
      status_next[DSW_BIT_FAULT] = state.protective_trip;
      status_next[DSW_BIT_SAFETY] = state.safety_circuit_fault;
      status_next[DSW_BIT_EDIT] = state.param_edit_enabled;
      status_next[DSW_BIT_NET_CMD] =
         state.network_command_allowed;
      status_next[DSW_BIT_CUR_DETECT] = cur_detect;
      status_next[DSW_BIT_ZERO_CUR] = zero_detect;
      status_next[DSW_BIT_READY] = ready_reg;
   end

   // unused life bit forced low by mask
   always_comb begin
      fault_next = 16'h0000;
      fault_next[DSW_FAULT_CODE_LSB +: 8] = state.fault_code;
      fault_next[DSW_LIFE_LSB +: 8] = state.life_flags &
                                      DSW_LIFE_MASK;
   end

   // all four words refresh every clock so a read is only one cycle older than live state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         drive_status_word <= DSW_WORD_RESET;
         fault_and_life_word <= DSW_WORD_RESET;
         output_frequency_word <= DSW_WORD_RESET;
         output_current_word <= DSW_WORD_RESET;
      end else begin
         drive_status_word <= status_next;
         fault_and_life_word <= fault_next;
         output_frequency_word <= state.output_frequency;
         output_current_word <= state.output_current;
      end
   end

   assign base = node_base(node_number);
   assign rd_offset = rd_addr - base;

   // read answers one cycle after the strobe; words are those latched
   // on the edge before, i.e. one cycle older than live state
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= DSW_WORD_RESET;
         rd_valid <= 1'b0;
         rd_miss <= 1'b0;
      end else if (!rd_strobe) begin
         rd_data <= DSW_WORD_RESET;
         rd_valid <= 1'b0;
         rd_miss <= 1'b0;
      end else if (rd_addr < base ||
                   rd_offset >= 16'(DSW_WORDS_PER_NODE)) begin
         rd_data <= DSW_WORD_RESET;
         rd_valid <= 1'b1;
         rd_miss <= 1'b1;
      end else if (rd_offset[1:0] == DSW_OFS_STATUS) begin
         rd_data <= drive_status_word;
         rd_valid <= 1'b1;
         rd_miss <= 1'b0;
      end else if (rd_offset[1:0] == DSW_OFS_FAULT) begin
         rd_data <= fault_and_life_word;
         rd_valid <= 1'b1;
         rd_miss <= 1'b0;
      end else if (rd_offset[1:0] == DSW_OFS_FREQ) begin
         rd_data <= output_frequency_word;
         rd_valid <= 1'b1;
         rd_miss <= 1'b0;
      end else begin
         rd_data <= output_current_word;
         rd_valid <= 1'b1;
         rd_miss <= 1'b0;
      end
   end
endmodule

// *** dsw_pkg.sv ***
/*
 * dsw_pkg: constants, field positions and carrier types for the drive
 * status input words.
 * Assumes a single 10 MHz reference clock; shared by dsw_top and
 * dsw_persist.
 */
package dsw_pkg;
   localparam int unsigned DSW_CLK_PERIOD_NS = 100;
   localparam int unsigned DSW_TICK_TIME_NS = 1000000;
   localparam int unsigned DSW_TICK_CYCLES =
      (DSW_TICK_TIME_NS + DSW_CLK_PERIOD_NS - 1) / DSW_CLK_PERIOD_NS;

   localparam int unsigned DSW_WORD_W = 16;
   localparam int unsigned DSW_WORDS_PER_NODE = 4;

   // word offsets from the node base
   localparam logic [1:0] DSW_OFS_STATUS = 2'h0;
   localparam logic [1:0] DSW_OFS_FAULT = 2'h1;
   localparam logic [1:0] DSW_OFS_FREQ = 2'h2;
   localparam logic [1:0] DSW_OFS_CURRENT = 2'h3;

   localparam logic [15:0] DSW_WORD_RESET = 16'h0000;
   localparam logic [7:0] DSW_NODE_FIRST = 8'h01;

   // status word bit positions
   localparam int unsigned DSW_BIT_FWD = 0;
   localparam int unsigned DSW_BIT_REV = 1;
   localparam int unsigned DSW_BIT_RUN = 2;
   localparam int unsigned DSW_BIT_UP_TO_FREQ = 3;
   localparam int unsigned DSW_BIT_OVERLOAD = 5;
   localparam int unsigned DSW_BIT_FREQ_DETECT = 6;
   localparam int unsigned DSW_BIT_FAULT = 7;
   localparam int unsigned DSW_BIT_SAFETY = 9;
   localparam int unsigned DSW_BIT_EDIT = 10;
   localparam int unsigned DSW_BIT_NET_CMD = 11;
   localparam int unsigned DSW_BIT_CUR_DETECT = 12;
   localparam int unsigned DSW_BIT_ZERO_CUR = 13;
   localparam int unsigned DSW_BIT_READY = 14;

   // fault word: code in low byte, life flags in high byte
   localparam int unsigned DSW_FAULT_CODE_LSB = 0;
   localparam int unsigned DSW_LIFE_LSB = 8;
   localparam logic [7:0] DSW_LIFE_MASK = 8'hBF;

   typedef struct packed {
      logic [15:0] starting_frequency_setting;
      logic [15:0] frequency_reach_band_setting;
      logic [15:0] forward_detect_threshold;
      logic [15:0] reverse_detect_threshold;
      logic [15:0] current_detect_level;
      logic [15:0] current_detect_time;
      logic [15:0] zero_current_level;
      logic [15:0] zero_current_time;
   } dsw_settings_t;

   typedef struct packed {
      logic output_active;
      logic direction_reverse;
      logic [15:0] output_frequency;
      logic [15:0] set_frequency;
      logic [15:0] output_current;
      logic stall_active;
      logic protective_trip;
      logic safety_circuit_fault;
      logic param_edit_enabled;
      logic network_command_allowed;
      logic startup_done;
      logic [7:0] fault_code;
      logic [7:0] life_flags;
   } dsw_state_t;
endpackage

// *** dsw_persist.sv ***
/*
 * dsw_persist: flags a condition that has held without a break for
 * longer than a programmable number of millisecond ticks.
 * Assumes tick is a one-cycle pulse from the parent, once per ms.
 */
`timescale 1ns/10ps
module dsw_persist
   import dsw_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic tick,
   input wire logic cond,
   input wire logic [15:0] limit,
   output logic flag
);
   logic [15:0] count_reg;

   // count resets whenever the condition drops; saturates at one past the limit
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 16'h0000;
      end else if (!cond) begin
         count_reg <= 16'h0000;
      end else if (tick && count_reg <= limit) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   // longer than the limit: strictly past it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else begin
         flag <= cond && (count_reg > limit);
      end
   end
endmodule

// *** dsw_chk.sv ***
/* dsw_chk: timing and value checks on the dsw_top ports.
   Assumes one clock, async active-low reset, node_number of 1 or more. */
`timescale 1ns/10ps
module dsw_chk
   import dsw_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = DSW_TICK_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire dsw_settings_t settings,
   input wire dsw_state_t state,
   input wire logic [7:0] node_number,
   input wire logic rd_strobe,
   input wire logic [15:0] rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic rd_miss,
   input wire logic [15:0] drive_status_word,
   input wire logic [15:0] fault_and_life_word,
   input wire logic [15:0] output_frequency_word,
   input wire logic [15:0] output_current_word
);
   logic live_reg;
   logic [15:0] base;
   logic hit;
   // words lag inputs by one edge, so skip the first edge after reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) live_reg <= 1'b0;
      else live_reg <= 1'b1;
   end
   assign base = 16'({node_number, 2'b00} - 10'h004);
   assign hit = rd_addr >= base && rd_addr <= base + 16'h0003;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_freq_req;
      rd_strobe && hit && rd_addr[1:0] == DSW_OFS_FREQ;
   endsequence
   sequence s_hit_answer;
      rd_valid && !rd_miss;
   endsequence
   a_read_freq: assert property (s_freq_req |=> s_hit_answer
      ##0 rd_data == $past(output_frequency_word)) else $error("bad read");
   a_read_miss: assert property (rd_strobe && !hit |=>
      rd_valid && rd_miss && rd_data == 16'h0000) else $error("bad miss");
   a_dir_bits: assert property (live_reg |->
      drive_status_word[1:0] == $past({state.output_active &
      state.direction_reverse, state.output_active &
      !state.direction_reverse})) else $error("direction bits wrong");
   a_run_bit: assert property (live_reg |->
      drive_status_word[2] ==
      $past(state.output_frequency >= settings.starting_frequency_setting))
      else $error("run bit wrong");
   a_stall_bit: assert property (live_reg |->
      drive_status_word[5] == $past(state.stall_active))
      else $error("overload bit wrong");
   a_unused_zero: assert property ({drive_status_word[15],
      drive_status_word[8], drive_status_word[4]} == 3'h0)
      else $error("unused bit set");
   a_fault_word: assert property (live_reg |->
      fault_and_life_word == $past({state.life_flags & DSW_LIFE_MASK,
      state.fault_code})) else $error("fault word wrong");
   a_value_words: assert property (live_reg |->
      {output_frequency_word, output_current_word} ==
      $past({state.output_frequency, state.output_current}))
      else $error("value word wrong");
   a_ready_bit: assert property (live_reg && $past(live_reg) |->
      drive_status_word[14] == $past(state.startup_done, 2))
      else $error("ready bit wrong");
   a_reset_zero: assert property (disable iff (1'b0) !rst_n |->
      {drive_status_word, fault_and_life_word, output_frequency_word,
      output_current_word} == 64'h0) else $error("word not cleared");
endmodule
bind dsw_top dsw_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.ref_clk(ref_clk),
   .rst_n(rst_n), .settings(settings), .state(state),
   .node_number(node_number), .rd_strobe(rd_strobe), .rd_addr(rd_addr),
   .rd_data(rd_data), .rd_valid(rd_valid), .rd_miss(rd_miss),
   .drive_status_word(drive_status_word),
   .fault_and_life_word(fault_and_life_word),
   .output_frequency_word(output_frequency_word),
   .output_current_word(output_current_word));

// *** dsw_master.sv ***
/* dsw_master: network master model reading node words one at a time.
   Assumes the answer stands in the cycle after the taking edge. */
`timescale 1ns/10ps
module dsw_master (
   input wire logic ref_clk,
   output logic rd_strobe,
   output logic [15:0] rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic rd_valid,
   input wire logic rd_miss
);
   initial begin
      rd_strobe = 1'b0;
      rd_addr = 16'hFFFF;
   end
   // released address inverted so a stale one never looks held
   task automatic read(input logic [15:0] a, output logic [15:0] d,
      output logic m, output logic v);
      @(posedge ref_clk);
      rd_strobe <= 1'b1;
      rd_addr <= a;
      @(posedge ref_clk);
      rd_strobe <= 1'b0;
      rd_addr <= ~a;
      #1;
      d = rd_data;
      m = rd_miss;
      v = rd_valid;
   endtask
endmodule

// *** tb_top.sv ***
/* tb_top: self-checking bench for dsw_top with a master model.
   Assumes dsw_pkg, dsw_chk and dsw_master are compiled before it. */
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb_top;
   import dsw_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b1;
   dsw_settings_t cfg = {16'h01F4, 16'h0064, 16'h07D0, 16'h0BB8,
      16'h0064, 16'h0002, 16'h000A, 16'h0002};
   dsw_state_t st = '0;
   logic [7:0] node = 8'h03;
   logic rd_strobe, rd_valid, rd_miss, m, v;
   logic [15:0] rd_addr, rd_data, sw, fw, ow, cw, d;
   logic [15:0] fo [5] = '{16'h01F3, 16'h01F4, 16'h07D0, 16'h07D0, 16'h0BB8};
   logic [15:0] fs [5] = '{16'h03E8, 16'h0258, 16'h0835, 16'h07D0, 16'h03E8};
   logic [3:0] fx [5] = '{4'h0, 4'h3, 4'h5, 4'hB, 4'hD};
   logic [15:0] ad [6] = '{16'h0008, 16'h0009, 16'h000A, 16'h000B,
      16'h0007, 16'h000C};
   logic [15:0] ex [6] = '{16'h4004, 16'hBF5A, 16'h04D2, 16'h004D,
      16'h0000, 16'h0000};
   int n_fail = 0;
   int n_compared = 0;
   always #50 ref_clk = ~ref_clk;
   dsw_top #(.TICK_CYCLES(4)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .settings(cfg), .state(st), .node_number(node),
      .rd_strobe(rd_strobe), .rd_addr(rd_addr), .rd_data(rd_data),
      .rd_valid(rd_valid), .rd_miss(rd_miss), .drive_status_word(sw),
      .fault_and_life_word(fw), .output_frequency_word(ow),
      .output_current_word(cw));
   dsw_master mst (.ref_clk(ref_clk), .rd_strobe(rd_strobe),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
      .rd_miss(rd_miss));
   task automatic settle;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_bit(input int b);
      for (int n = 0; n < 40 && sw[b] !== 1'b1; n++) settle;
      `CHK(sw[b], 1'b1)
   endtask
   task automatic t_reset;
      repeat (7) @(posedge ref_clk);
      st.startup_done <= 1'b1;
      st.output_frequency <= 16'h1234;
      settle;
      `CHK({sw, fw, ow, cw}, 64'h0)
      @(posedge ref_clk);
      rst_n <= 1'b1;
      settle;
      `CHK(sw[14], 1'b0)
      `CHK(ow, 16'h1234)
      settle;
      `CHK(sw[14], 1'b1)
      $display("test reset done");
   endtask
   task automatic t_dir;
      for (int i = 0; i < 4; i++) begin
         @(posedge ref_clk);
         {st.output_active, st.direction_reverse} <= i[1:0];
         settle;
         `CHK(sw[1:0], {i[1] & i[0], i[1] & ~i[0]})
      end
      $display("test direction done");
   endtask
   task automatic t_flags;
      for (int k = 0; k < 6; k++) begin
         @(posedge ref_clk);
         {st.stall_active, st.protective_trip, st.safety_circuit_fault,
            st.param_edit_enabled, st.network_command_allowed} <= 5'h10 >> k;
         settle;
         `CHK(sw[5], k == 0)
         `CHK(sw[7], k == 1)
         `CHK(sw[9], k == 2)
         `CHK(sw[10], k == 3)
         `CHK(sw[11], k == 4)
         `CHK({sw[15], sw[8], sw[4]}, 3'h0)
      end
      $display("test flags done");
   endtask
   task automatic t_freq;
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk);
         st.output_active <= 1'b1;
         st.direction_reverse <= fx[i][3];
         st.output_frequency <= fo[i];
         st.set_frequency <= fs[i];
         settle;
         `CHK({sw[6], sw[3], sw[2]}, fx[i][2:0])
      end
      $display("test frequency done");
   endtask
   task automatic t_cur;
      @(posedge ref_clk);
      st.output_current <= 16'h0096;
      repeat (5) settle;
      `CHK(sw[13:12], 2'b00)
      `CHK(cw, 16'h0096)
      wait_bit(12);
      @(posedge ref_clk);
      st.output_current <= 16'h0005;
      repeat (3) settle;
      `CHK(sw[13:12], 2'b00)
      wait_bit(13);
      $display("test current done");
   endtask
   task automatic t_read;
      @(posedge ref_clk);
      st.output_active <= 1'b0;
      st.output_frequency <= 16'h04D2;
      st.output_current <= 16'h004D;
      st.fault_code <= 8'h5A;
      st.life_flags <= 8'hFF;
      repeat (3) settle;
      for (int i = 0; i < 6; i++) begin
         mst.read(ad[i], d, m, v);
         `CHK({v, m, d}, {1'b1, i > 3, ex[i]})
      end
      // the answer stands one cycle only
      settle;
      `CHK({rd_valid, rd_miss, rd_data}, 18'h00000)
      // a second node number moves the base to zero
      @(posedge ref_clk);
      node <= 8'h01;
      mst.read(16'h0003, d, m, v);
      `CHK({v, m, d}, {2'b10, ex[3]})
      mst.read(16'h0008, d, m, v);
      `CHK({v, m, d}, {2'b11, 16'h0000})
      $display("test read done");
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #1 rst_n = 1'b0;
      t_reset;
      t_dir;
      t_flags;
      t_freq;
      t_cur;
      t_read;
      conclude;
   end
   // whole run is under a hundred cycles; a thousand means a hang
   initial begin
      #100000;
      n_fail++;
      conclude;
   end
endmodule
